// ===== rtl/core_regs_cfg.svh
// Constants for the processor core register set
`ifndef CORE_REGS_CFG_SVH
`define CORE_REGS_CFG_SVH
`define STACK_TOP_RST 16'h00ff
`define INDEX_UPPER_RST 8'h00
`define RESET_VEC_HI 16'hfffe
`define RESET_VEC_LO 16'hffff
`define DIRECT_PAGE 8'h00
`define FLAG_V 7
`define FLAG_ONE6 6
`define FLAG_ONE5 5
`define FLAG_H 4
`define FLAG_I 3
`define FLAG_N 2
`define FLAG_Z 1
`define FLAG_C 0
`define FLAG_RST 8'h68
`define DIV_STEPS 8
`endif

// ===== rtl/core_regs_pkg.sv
// Types for the processor core register set
package core_regs_pkg;
    typedef enum logic [4:0] {
        OP_NOP, OP_ADD, OP_ADC, OP_SUB, OP_AND, OP_OR, OP_XOR, OP_LDA,
        OP_TXA, OP_TAX, OP_CLRX, OP_INCX, OP_DECX, OP_COMX, OP_NEGX,
        OP_LSLX, OP_LSRX, OP_ROLX, OP_RORX, OP_LDHX, OP_LDX,
        OP_MUL, OP_DIV, OP_AIS, OP_RSP, OP_LDSP, OP_PUSH, OP_PULL,
        OP_CALL, OP_INT, OP_RET
    } core_op_e;
    typedef enum logic [2:0] {
        AM_INH, AM_DIR, AM_EXT, AM_IDX, AM_SPX, AM_REL
    } addr_mode_e;
endpackage

// ===== rtl/cpu_core_registers.sv
// Programmer-visible register set and datapath of the processor core
`timescale 1ns/1ps
`include "core_regs_cfg.svh"
// Overview of operation
// - sum_register is an 8-bit register that reset leaves alone.
// - ALU takes one operand from sum_register and writes results back.
// - pointer_pair is index_upper_byte over pointer_low_byte, 16 bits.
// - Indexed accesses address with the full 16-bit pointer_pair.
// - Some operations touch only pointer_low_byte, never index_upper_byte.
// - pointer_low_byte clears, steps, complements, negates, shifts, rotates.
// - Reset zeroes index_upper_byte and keeps pointer_low_byte.
// - stack_top is 16 bits, points to next free stack location.
// - Reset loads stack_top with 0x00ff.
// - stack_offset_add adds sign-extended 8-bit immediate to stack_top.
// - stack_low_reinit changes only the low byte of stack_top.
// - Calls push return address; interrupts push it, pointer_low_byte, sum_register and flag_reg.
// - Core registers are reached by instructions only, not memory map.
// - One linear 64-Kbyte space addressed by 16-bit pointers.
// - Direct operands use a zero upper address byte.
// - Relative branches add a signed 8-bit displacement to fetch_pointer.
// - Overflow, half-carry, negative, zero and carry flags are produced.
// - Datapath has 8x8 multiply and 16/8 divide.
// - Reset loads fetch_pointer from two i_mem_rdata bytes; o_mem_addr does not give the vector address.
// - flag_reg bits 6 and 5 always read one.
module cpu_core_registers (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst_b,
    // Instruction request from decode
    input wire logic i_op_valid,
    input wire core_regs_pkg::core_op_e i_op,
    input wire core_regs_pkg::addr_mode_e i_mode,
    input wire logic [7:0] i_imm,
    input wire logic [15:0] i_ext_addr,
    input wire logic [15:0] i_ret_addr,
    input wire logic i_branch_take,
    // Memory data in
    input wire logic [7:0] i_mem_rdata,
    // Operand address and stack traffic
    output logic [15:0] o_ea,
    output logic o_mem_we,
    output logic o_mem_re,
    output logic [15:0] o_mem_addr,
    output logic [7:0] o_mem_wdata,
    output logic o_busy,
    // Register views, instruction use only
    output logic [7:0] o_sum_register,
    output logic [15:0] o_pointer_pair,
    output logic [15:0] o_stack_top,
    output logic [15:0] o_fetch_pointer,
    output logic [7:0] o_flag_reg
);
    // ****************************************
    // Registers
    // ****************************************
    logic [7:0] sum_reg;
    logic [7:0] hi_reg;
    logic [7:0] lo_reg;
    logic [15:0] sp_reg;
    logic [15:0] pc_reg;
    logic [7:0] ccr_reg;
    logic [1:0] vec_reg;
    logic [7:0] vec_hi_reg;
    logic [7:0] pull_cnt_reg;
    logic [15:0] ret_pull_reg;
    logic go;
    logic [7:0] alu_b;
    logic [8:0] alu_res;
    logic [7:0] x_next;
    logic x_c;
    logic [15:0] prod;
    logic [15:0] quo;
    logic [7:0] rem;
    logic div_ok;
    logic seq_busy;
    logic seq_step;
    logic seq_pull;
    logic [7:0] seq_byte;
    logic seq_start;
    logic seq_is_pull;
    logic [2:0] seq_count;
    logic [39:0] seq_bytes;

    assign go = i_op_valid && !o_busy && vec_reg == 2'h0;

    // ****************************************
    // Address forming
    // ****************************************
    always_comb begin
        case (i_mode)
            core_regs_pkg::AM_DIR: o_ea = {`DIRECT_PAGE, i_imm};
            core_regs_pkg::AM_IDX: o_ea = {hi_reg, lo_reg};
            core_regs_pkg::AM_SPX: o_ea = sp_reg + {8'h00, i_imm} + 16'h0001;
            core_regs_pkg::AM_EXT: o_ea = i_ext_addr;
            default: o_ea = 16'h0000;
        endcase
    end
    assign alu_b = (i_mode == core_regs_pkg::AM_INH) ? i_imm : i_mem_rdata;

    // ****************************************
    // ALU on the accumulator
    // ****************************************
    always_comb begin
        case (i_op)
            core_regs_pkg::OP_ADD: alu_res = {1'b0, sum_reg} + {1'b0, alu_b};
            core_regs_pkg::OP_ADC: alu_res = {1'b0, sum_reg} + {1'b0, alu_b}
                + {8'h00, ccr_reg[`FLAG_C]};
            core_regs_pkg::OP_SUB: alu_res = {1'b0, sum_reg} - {1'b0, alu_b};
            core_regs_pkg::OP_AND: alu_res = {1'b0, sum_reg & alu_b};
            core_regs_pkg::OP_OR: alu_res = {1'b0, sum_reg | alu_b};
            core_regs_pkg::OP_XOR: alu_res = {1'b0, sum_reg ^ alu_b};
            core_regs_pkg::OP_LDA: alu_res = {1'b0, alu_b};
            core_regs_pkg::OP_TXA: alu_res = {1'b0, lo_reg};
            default: alu_res = {1'b0, sum_reg};
        endcase
    end

    // ****************************************
    // Low pointer byte as a data register
    // ****************************************
    always_comb begin
        x_c = ccr_reg[`FLAG_C];
        case (i_op)
            core_regs_pkg::OP_CLRX: x_next = 8'h00;
            core_regs_pkg::OP_INCX: x_next = lo_reg + 8'h01;
            core_regs_pkg::OP_DECX: x_next = lo_reg - 8'h01;
            core_regs_pkg::OP_COMX: begin
                x_next = ~lo_reg;
                x_c = 1'b1;
            end
            core_regs_pkg::OP_NEGX: begin
                x_next = 8'h00 - lo_reg;
                x_c = (lo_reg != 8'h00);
            end
            core_regs_pkg::OP_LSLX: begin
                x_next = {lo_reg[6:0], 1'b0};
                x_c = lo_reg[7];
            end
            core_regs_pkg::OP_LSRX: begin
                x_next = {1'b0, lo_reg[7:1]};
                x_c = lo_reg[0];
            end
            core_regs_pkg::OP_ROLX: begin
                x_next = {lo_reg[6:0], ccr_reg[`FLAG_C]};
                x_c = lo_reg[7];
            end
            core_regs_pkg::OP_RORX: begin
                x_next = {ccr_reg[`FLAG_C], lo_reg[7:1]};
                x_c = lo_reg[0];
            end
            core_regs_pkg::OP_TAX: x_next = sum_reg;
            core_regs_pkg::OP_LDX: x_next = alu_b;
            default: x_next = lo_reg;
        endcase
    end

    // Multiply and divide, single cycle at this clock rate
    assign prod = {8'h00, sum_reg} * {8'h00, lo_reg};
    assign div_ok = (lo_reg != 8'h00);
    assign quo = div_ok ? {hi_reg, sum_reg} / {8'h00, lo_reg} : 16'hffff;
    assign rem = div_ok ? 8'(({hi_reg, sum_reg}) % {8'h00, lo_reg}) : sum_reg;

    // ****************************************
    // Accumulator, no reset by design
    // ****************************************
    always_ff @(posedge i_core_clk) begin
        if (go && (i_op inside {core_regs_pkg::OP_ADD, core_regs_pkg::OP_ADC,
            core_regs_pkg::OP_SUB, core_regs_pkg::OP_AND, core_regs_pkg::OP_OR,
            core_regs_pkg::OP_XOR, core_regs_pkg::OP_LDA, core_regs_pkg::OP_TXA})) begin
            sum_reg <= alu_res[7:0];
        end else if (go && i_op == core_regs_pkg::OP_MUL) begin
            sum_reg <= prod[7:0];
        end else if (go && i_op == core_regs_pkg::OP_DIV) begin
            sum_reg <= quo[7:0];
        end
    end

    // Low byte keeps its value through reset
    always_ff @(posedge i_core_clk) begin
        if (go && i_op == core_regs_pkg::OP_LDHX) begin
            lo_reg <= i_ext_addr[7:0];
        end else if (go && i_op == core_regs_pkg::OP_MUL) begin
            lo_reg <= prod[15:8];
        end else if (go) begin
            lo_reg <= x_next;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            hi_reg <= `INDEX_UPPER_RST;
        end else if (go && i_op == core_regs_pkg::OP_LDHX) begin
            hi_reg <= i_ext_addr[15:8];
        end else if (go && i_op == core_regs_pkg::OP_DIV) begin
            hi_reg <= rem;
        end
    end

    // ****************************************
    // Stack pointer
    // ****************************************
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            sp_reg <= `STACK_TOP_RST;
        end else if (seq_step) begin
            sp_reg <= seq_pull ? sp_reg + 16'h0001 : sp_reg - 16'h0001;
        end else if (go && i_op == core_regs_pkg::OP_AIS) begin
            sp_reg <= sp_reg + {{8{i_imm[7]}}, i_imm};
        end else if (go && i_op == core_regs_pkg::OP_RSP) begin
            sp_reg <= {sp_reg[15:8], 8'hff};
        end else if (go && i_op == core_regs_pkg::OP_LDSP) begin
            sp_reg <= i_ext_addr;
        end
    end

    // ****************************************
    // Stack traffic
    // ****************************************
    always_comb begin
        seq_start = go && (i_op inside {core_regs_pkg::OP_PUSH, core_regs_pkg::OP_PULL,
            core_regs_pkg::OP_CALL, core_regs_pkg::OP_INT, core_regs_pkg::OP_RET});
        seq_is_pull = (i_op == core_regs_pkg::OP_PULL) || (i_op == core_regs_pkg::OP_RET);
        case (i_op)
            core_regs_pkg::OP_CALL: seq_count = 3'h2;
            core_regs_pkg::OP_INT: seq_count = 3'h5;
            core_regs_pkg::OP_RET: seq_count = 3'h2;
            default: seq_count = 3'h1;
        endcase
        // Interrupt frame: return low, return high, low pointer, sum, flags
        seq_bytes = {ccr_reg, sum_reg, lo_reg, i_ret_addr[15:8], i_ret_addr[7:0]};
        if (i_op == core_regs_pkg::OP_PUSH) begin
            seq_bytes = {32'h0, sum_reg};
        end
    end

    stack_seq #(
        .MAX_BYTES(5)
    ) u_stack_seq (
        .i_core_clk(i_core_clk),
        .i_rst_b(i_rst_b),
        .i_start(seq_start),
        .i_pull(seq_is_pull),
        .i_count(seq_count),
        .i_bytes(seq_bytes),
        .o_busy(seq_busy),
        .o_step(seq_step),
        .o_step_pull(seq_pull),
        .o_byte(seq_byte)
    );

    // Push writes at the current pointer; pull reads one above it
    assign o_mem_addr = seq_pull ? sp_reg + 16'h0001 : sp_reg;
    assign o_mem_we = seq_step && !seq_pull;
    assign o_mem_re = seq_step && seq_pull;
    assign o_mem_wdata = seq_byte;
    assign o_busy = seq_busy;

    // ****************************************
    // Flags
    // ****************************************
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            ccr_reg <= `FLAG_RST;
        end else if (go && (i_op inside {core_regs_pkg::OP_ADD, core_regs_pkg::OP_ADC,
            core_regs_pkg::OP_SUB})) begin
            ccr_reg[`FLAG_C] <= alu_res[8];
            ccr_reg[`FLAG_H] <= (sum_reg[4] ^ alu_b[4] ^ alu_res[4]);
            ccr_reg[`FLAG_V] <= (i_op == core_regs_pkg::OP_SUB)
                ? (sum_reg[7] ^ alu_b[7]) & (sum_reg[7] ^ alu_res[7])
                : ~(sum_reg[7] ^ alu_b[7]) & (sum_reg[7] ^ alu_res[7]);
            ccr_reg[`FLAG_N] <= alu_res[7];
            ccr_reg[`FLAG_Z] <= (alu_res[7:0] == 8'h00);
        end else if (go && (i_op inside {core_regs_pkg::OP_AND, core_regs_pkg::OP_OR,
            core_regs_pkg::OP_XOR, core_regs_pkg::OP_LDA})) begin
            ccr_reg[`FLAG_V] <= 1'b0;
            ccr_reg[`FLAG_N] <= alu_res[7];
            ccr_reg[`FLAG_Z] <= (alu_res[7:0] == 8'h00);
        end else if (go && (i_op inside {core_regs_pkg::OP_CLRX, core_regs_pkg::OP_INCX,
            core_regs_pkg::OP_DECX, core_regs_pkg::OP_COMX, core_regs_pkg::OP_NEGX,
            core_regs_pkg::OP_LSLX, core_regs_pkg::OP_LSRX, core_regs_pkg::OP_ROLX,
            core_regs_pkg::OP_RORX})) begin
            ccr_reg[`FLAG_C] <= x_c;
            ccr_reg[`FLAG_N] <= x_next[7];
            ccr_reg[`FLAG_Z] <= (x_next == 8'h00);
        end else if (go && i_op == core_regs_pkg::OP_MUL) begin
            ccr_reg[`FLAG_C] <= 1'b0;
            ccr_reg[`FLAG_H] <= 1'b0;
        end else if (go && i_op == core_regs_pkg::OP_DIV) begin
            ccr_reg[`FLAG_C] <= !div_ok || (quo[15:8] != 8'h00);
            ccr_reg[`FLAG_Z] <= (quo[7:0] == 8'h00);
        end else if (go && i_op == core_regs_pkg::OP_INT) begin
            ccr_reg[`FLAG_I] <= 1'b1;
        end
    end
    assign o_flag_reg = {ccr_reg[7], 2'b11, ccr_reg[4:0]};

    // ****************************************
    // Fetch pointer and reset vector load
    // ****************************************
    // Vector bytes come over the memory read port after release, two cycles
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            vec_reg <= 2'h2;
            vec_hi_reg <= 8'h00;
            pc_reg <= 16'h0000;
        end else if (vec_reg == 2'h2) begin
            vec_reg <= 2'h1;
            vec_hi_reg <= i_mem_rdata;
        end else if (vec_reg == 2'h1) begin
            vec_reg <= 2'h0;
            pc_reg <= {vec_hi_reg, i_mem_rdata};
        end else if (go && i_mode == core_regs_pkg::AM_REL && i_branch_take) begin
            pc_reg <= pc_reg + {{8{i_imm[7]}}, i_imm};
        end else if (go && i_op == core_regs_pkg::OP_LDSP) begin
            pc_reg <= pc_reg;
        end
    end

    assign o_sum_register = sum_reg;
    assign o_pointer_pair = {hi_reg, lo_reg};
    assign o_stack_top = sp_reg;
    assign o_fetch_pointer = pc_reg;

    // ****************************************
    // Checks
    // ****************************************
    a_flag_ones: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
        o_flag_reg[6:5] == 2'b11) else $error("flag bits 6,5 not one");
    a_ais_add: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
        go && i_op == core_regs_pkg::OP_AIS |=> sp_reg == $past(sp_reg)
            + {{8{$past(i_imm[7])}}, $past(i_imm)}) else $error("stack add wrong");
    a_rsp_high: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
        go && i_op == core_regs_pkg::OP_RSP |=> sp_reg[15:8] == $past(sp_reg[15:8]))
        else $error("reinit touched high byte");
    a_push_dec: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
        o_mem_we |-> o_mem_addr == sp_reg ##1 sp_reg == $past(sp_reg) - 16'h0001)
        else $error("push order wrong");
    a_call_two: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
        go && i_op == core_regs_pkg::OP_CALL |=> o_mem_we [*2] ##1 !o_busy)
        else $error("call push count wrong");
    a_dir_page: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
        i_mode == core_regs_pkg::AM_DIR |-> o_ea[15:8] == 8'h00)
        else $error("direct page high byte");
    a_idx_full: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
        i_mode == core_regs_pkg::AM_IDX |-> o_ea == o_pointer_pair)
        else $error("indexed address wrong");
    a_x_only: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
        go && i_op == core_regs_pkg::OP_INCX |=> hi_reg == $past(hi_reg))
        else $error("upper byte disturbed");
    a_rst_sp: assert property (@(posedge i_core_clk)
        $rose(i_rst_b) |-> sp_reg == 16'h00ff) else $error("stack reset value");
endmodule

// ===== rtl/stack_seq.sv
// Sequencer that streams byte pushes and pulls through the stack
`timescale 1ns/1ps
`include "core_regs_cfg.svh"
module stack_seq #(
    parameter int MAX_BYTES = 5
) (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst_b,
    // Request
    input wire logic i_start,
    input wire logic i_pull,
    input wire logic [2:0] i_count,
    input wire logic [39:0] i_bytes,
    // Progress
    output logic o_busy,
    output logic o_step,
    output logic o_step_pull,
    output logic [7:0] o_byte
);
    logic [2:0] left_reg;
    logic pull_reg;
    logic [39:0] sh_reg;

    if (MAX_BYTES < 1 || MAX_BYTES > 5) begin : g_bad_max
        $error("stack_seq: MAX_BYTES must be 1 to 5");
    end

    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            left_reg <= 3'h0;
            pull_reg <= 1'b0;
            sh_reg <= 40'h0;
        end else if (left_reg == 3'h0 && i_start && i_count != 3'h0) begin
            left_reg <= i_count;
            pull_reg <= i_pull;
            sh_reg <= i_bytes;
        end else if (left_reg != 3'h0) begin
            left_reg <= left_reg - 3'h1;
            sh_reg <= {8'h00, sh_reg[39:8]};
        end
    end

    // Byte comes straight off the shift flops so it lines up with its strobe
    assign o_byte = sh_reg[7:0];

    assign o_busy = (left_reg != 3'h0);
    assign o_step = o_busy;
    assign o_step_pull = pull_reg;
endmodule

// ===== verif/tb_cpu_core_registers.sv
// Self-checking testbench for the processor core register set
`timescale 1ns/1ps
module tb_cpu_core_registers;
    // ****************
    // Signals
    // ****************
    logic i_core_clk;
    logic i_rst_b;
    logic i_op_valid;
    core_regs_pkg::core_op_e i_op;
    core_regs_pkg::addr_mode_e i_mode;
    logic [7:0] i_imm;
    logic [15:0] i_ext_addr;
    logic [15:0] i_ret_addr;
    logic i_branch_take;
    logic [7:0] i_mem_rdata;
    logic [15:0] o_ea;
    logic o_mem_we;
    logic o_mem_re;
    logic [15:0] o_mem_addr;
    logic [7:0] o_mem_wdata;
    logic o_busy;
    logic [7:0] o_sum_register;
    logic [15:0] o_pointer_pair;
    logic [15:0] o_stack_top;
    logic [15:0] o_fetch_pointer;
    logic [7:0] o_flag_reg;
    int err_total = 0;
    int total_checks = 0;
    logic [7:0] wr_q[$];
    logic [15:0] ad_q[$];
    // ****************
    // Design
    // ****************
    cpu_core_registers uut (
        .i_core_clk(i_core_clk),
        .i_rst_b(i_rst_b),
        .i_op_valid(i_op_valid),
        .i_op(i_op),
        .i_mode(i_mode),
        .i_imm(i_imm),
        .i_ext_addr(i_ext_addr),
        .i_ret_addr(i_ret_addr),
        .i_branch_take(i_branch_take),
        .i_mem_rdata(i_mem_rdata),
        .o_ea(o_ea),
        .o_mem_we(o_mem_we),
        .o_mem_re(o_mem_re),
        .o_mem_addr(o_mem_addr),
        .o_mem_wdata(o_mem_wdata),
        .o_busy(o_busy),
        .o_sum_register(o_sum_register),
        .o_pointer_pair(o_pointer_pair),
        .o_stack_top(o_stack_top),
        .o_fetch_pointer(o_fetch_pointer),
        .o_flag_reg(o_flag_reg)
    );
    // ****************
    // Helpers
    // ****************
    initial begin
        i_core_clk = 1'b0;
        forever #50 i_core_clk = ~i_core_clk;
    end
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    // One request, held across its taking edge
    task automatic op(input core_regs_pkg::core_op_e c, input core_regs_pkg::addr_mode_e m,
            input logic [7:0] v, input logic [15:0] e, input logic [15:0] ea);
        @(negedge i_core_clk);
        i_op = c;
        i_mode = m;
        i_imm = v;
        i_mem_rdata = v;
        i_ext_addr = e;
        i_op_valid = 1'b1;
        #10;
        if (m != core_regs_pkg::AM_INH) begin
            chk(o_ea, ea, "operand address");
        end
        @(negedge i_core_clk);
        i_op_valid = 1'b0;
    endtask
    // Stack op; strobes last one cycle, so sample every cycle
    task automatic stk(input core_regs_pkg::core_op_e c, input int n);
        int i;
        logic w;
        w = !(c == core_regs_pkg::OP_PULL || c == core_regs_pkg::OP_RET);
        wr_q.delete();
        ad_q.delete();
        op(c, core_regs_pkg::AM_INH, 8'h00, 16'h0000, 16'h0000);
        for (i = 0; i < 20; i++) begin
            if (o_mem_we === 1'b1 || o_mem_re === 1'b1) begin
                chk({15'h0, o_mem_we}, {15'h0, w}, "strobe kind");
                wr_q.push_back(o_mem_wdata);
                ad_q.push_back(o_mem_addr);
            end
            if (o_busy !== 1'b1) break;
            @(negedge i_core_clk);
        end
        if (i == 20) begin
            err_total++;
            $display("CHECK FAILED at %0t: stack sequence hung", $time);
            give_verdict();
        end
        chk(wr_q.size(), n[15:0], "stack beats");
    endtask
    // ****************
    // Scenarios
    // ****************
    task automatic t_reset(input logic [7:0] a, input logic [7:0] x);
        @(negedge i_core_clk);
        i_rst_b = 1'b0;
        i_mem_rdata = 8'hc1;
        repeat (6) @(negedge i_core_clk);
        chk(o_stack_top, 16'h00ff, "sp at reset");
        chk(o_pointer_pair, {8'h00, x}, "index at reset");
        chk({8'h00, o_sum_register}, {8'h00, a}, "acc kept");
        chk({8'h00, o_flag_reg}, 16'h0068, "flags at reset");
        i_rst_b = 1'b1;
        @(negedge i_core_clk);
        i_mem_rdata = 8'h23;
        @(negedge i_core_clk);
        chk(o_fetch_pointer, 16'hc123, "vector");
    endtask
    task automatic t_alu();
        op(core_regs_pkg::OP_LDA, core_regs_pkg::AM_DIR, 8'h7f, 16'h0, 16'h007f);
        op(core_regs_pkg::OP_ADD, core_regs_pkg::AM_DIR, 8'h01, 16'h0, 16'h0001);
        chk({8'h00, o_sum_register}, 16'h0080, "add");
        chk({8'h00, o_flag_reg}, 16'h00fc, "add flags");
        op(core_regs_pkg::OP_SUB, core_regs_pkg::AM_EXT, 8'h80, 16'hf345, 16'hf345);
        chk({8'h00, o_sum_register}, 16'h0000, "sub");
        chk({14'h0, o_flag_reg[1:0]}, 16'h0002, "sub z c");
    endtask
    task automatic t_index();
        core_regs_pkg::core_op_e ops[9] = '{core_regs_pkg::OP_INCX, core_regs_pkg::OP_DECX,
            core_regs_pkg::OP_COMX, core_regs_pkg::OP_NEGX, core_regs_pkg::OP_LSLX,
            core_regs_pkg::OP_LSRX, core_regs_pkg::OP_ROLX, core_regs_pkg::OP_RORX,
            core_regs_pkg::OP_CLRX};
        logic [7:0] res[9] = '{8'h35, 8'h34, 8'hcb, 8'h35, 8'h6a, 8'h35, 8'h6a, 8'h35, 8'h00};
        op(core_regs_pkg::OP_LDHX, core_regs_pkg::AM_INH, 8'h00, 16'h1234, 16'h0);
        chk(o_pointer_pair, 16'h1234, "index load");
        for (int k = 0; k < 9; k++) begin
            op(ops[k], core_regs_pkg::AM_INH, 8'h00, 16'h0, 16'h0);
            chk(o_pointer_pair, {8'h12, res[k]}, "low byte op");
        end
        op(core_regs_pkg::OP_LDA, core_regs_pkg::AM_IDX, 8'h00, 16'h0, 16'h1200);
    endtask
    task automatic t_muldiv();
        op(core_regs_pkg::OP_LDHX, core_regs_pkg::AM_INH, 8'h00, 16'h0010, 16'h0);
        op(core_regs_pkg::OP_LDA, core_regs_pkg::AM_DIR, 8'h12, 16'h0, 16'h0012);
        op(core_regs_pkg::OP_MUL, core_regs_pkg::AM_INH, 8'h00, 16'h0, 16'h0);
        chk({o_pointer_pair[7:0], o_sum_register}, 16'h0120, "mul");
        op(core_regs_pkg::OP_LDHX, core_regs_pkg::AM_INH, 8'h00, 16'h0107, 16'h0);
        op(core_regs_pkg::OP_LDA, core_regs_pkg::AM_DIR, 8'h00, 16'h0, 16'h0000);
        op(core_regs_pkg::OP_DIV, core_regs_pkg::AM_INH, 8'h00, 16'h0, 16'h0);
        chk({o_pointer_pair[15:8], o_sum_register}, 16'h0424, "div");
    endtask
    task automatic t_stack();
        op(core_regs_pkg::OP_LDSP, core_regs_pkg::AM_INH, 8'h00, 16'h0180, 16'h0);
        chk(o_stack_top, 16'h0180, "sp load");
        op(core_regs_pkg::OP_AIS, core_regs_pkg::AM_INH, 8'hfe, 16'h0, 16'h0);
        chk(o_stack_top, 16'h017e, "add negative");
        op(core_regs_pkg::OP_AIS, core_regs_pkg::AM_INH, 8'h10, 16'h0, 16'h0);
        chk(o_stack_top, 16'h018e, "add positive");
        op(core_regs_pkg::OP_RSP, core_regs_pkg::AM_INH, 8'h00, 16'h0, 16'h0);
        chk(o_stack_top, 16'h01ff, "low reinit");
        op(core_regs_pkg::OP_LDHX, core_regs_pkg::AM_INH, 8'h00, 16'h0077, 16'h0);
        op(core_regs_pkg::OP_LDA, core_regs_pkg::AM_DIR, 8'h5a, 16'h0, 16'h005a);
        stk(core_regs_pkg::OP_PUSH, 1);
        chk(ad_q[0], 16'h01ff, "push addr");
        chk({8'h00, wr_q[0]}, 16'h005a, "push data");
        chk(o_stack_top, 16'h01fe, "push sp");
        stk(core_regs_pkg::OP_PULL, 1);
        chk(ad_q[0], 16'h01ff, "pull addr");
        chk(o_stack_top, 16'h01ff, "pull sp");
        stk(core_regs_pkg::OP_CALL, 2);
        chk({wr_q[0], wr_q[1]}, 16'hefbe, "call bytes");
        chk(ad_q[1], 16'h01fe, "call addr");
        chk(o_stack_top, 16'h01fd, "call sp");
        stk(core_regs_pkg::OP_RET, 2);
        chk(o_stack_top, 16'h01ff, "ret sp");
        stk(core_regs_pkg::OP_INT, 5);
        chk({wr_q[2], wr_q[3]}, 16'h775a, "int regs");
        chk(o_stack_top, 16'h01fa, "int sp");
    endtask
    task automatic t_branch();
        i_branch_take = 1'b1;
        op(core_regs_pkg::OP_NOP, core_regs_pkg::AM_REL, 8'hf0, 16'h0, 16'h0000);
        chk(o_fetch_pointer, 16'hc113, "branch back");
        op(core_regs_pkg::OP_NOP, core_regs_pkg::AM_REL, 8'h25, 16'h0, 16'h0000);
        chk(o_fetch_pointer, 16'hc138, "branch forward");
        i_branch_take = 1'b0;
        op(core_regs_pkg::OP_NOP, core_regs_pkg::AM_REL, 8'h25, 16'h0, 16'h0000);
        chk(o_fetch_pointer, 16'hc138, "branch not taken");
    endtask
    // ****************
    // Main sequence
    // ****************
    initial begin
        i_rst_b = 1'b0;
        i_op_valid = 1'b0;
        i_op = core_regs_pkg::OP_NOP;
        i_mode = core_regs_pkg::AM_INH;
        i_imm = 8'h00;
        i_ext_addr = 16'h0000;
        i_ret_addr = 16'hbeef;
        i_branch_take = 1'b0;
        i_mem_rdata = 8'h00;
        t_reset(8'hxx, 8'hxx);
        t_alu();
        t_index();
        t_muldiv();
        t_stack();
        t_reset(8'h5a, 8'h77);
        t_branch();
        give_verdict();
    end
endmodule
